/* tape_order_map.vh */
`ifndef TAPE_ORDER_MAP_VH
`define TAPE_ORDER_MAP_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define REG_CONTROL        8'h00
`define REG_STATUS         8'h04
`define REG_TRACK_ERROR    8'h08
`define REG_ERROR_PATTERN  8'h0C
`define REG_FLAG_CLEAR     8'h10

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTL_ORDER_LSB      0
`define CTL_ORDER_MSB      4
`define CTL_WRITE_BUSY     5
`define CTL_SHIFT          6
`define CTL_START          8

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define ST_STATE_A         0
`define ST_STATE_B         1
`define ST_TERMINAL        2
`define ST_SERVICE_CYCLE   3
`define ST_COMPLETE        4
`define ST_UNUSUAL_END     5
`define ST_CORR_READ       6
`define ST_INTERRUPT       7
`define ST_REQUEST         8

// ----------------------------------------
// Reset values and order codes
// ----------------------------------------
`define RST_CONTROL        7'h00
`define RST_TRACK_ERROR    8'h00
`define RST_PATTERN        9'h000
`define ORDER_SENSE        5'h04

// ----------------------------------------
// Data line positions
// ----------------------------------------
`define DL_INTERRUPT       0
`define DL_HALT            3

`endif

/* tape_order_phase_sequencer.v */
// What this block does
// - Order out, end data without end service, cycle flag set: set terminal flag at fall.
// - Terminal order: re-raise request; at fall clear state b, terminal and cycle flags.
// - End service with halt on line three in terminal order sets unusual end, back to order input.
// - No erase and no halt: set state a at fall, entering device select time.
// - Device select time is state a set, b clear; one of two phases, sense or set correction, follows.
// - Sense phase asserted when order flags hold only the third bit.
// - During sense the stored track error byte drives the host data lines.
// - Sense: service call, then strobe fall sets cycle flag, request and enables.
// - Sense with end service: at fall set complete, clear state a and cycle.
// - Sense without end service: at fall set terminal, keep state a and cycle.
// - Sense terminal order: at fall set complete, clear state a, terminal, cycle.
// - Sense or correction terminal order with line zero sets interrupt flag.
// - Sense or correction terminal order with halt sets unusual end flag.
// - Set correction phase when first order flag set, third to fifth clear.
// - Entering set correction with cycle flag clear: data reset and service call.
// - Correction strobe: output direction, end data; load gate while request, no terminal.
// - Correction with end service: at fall set read and complete, clear a, cycle.
// - Nine stage pattern register set from data lines under load gate, not write busy or shifting.
// - Correction without end service: at fall set read and terminal, keep a, cycle.
// - Correction terminal order: at fall set complete, clear a, terminal, cycle.
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tape_order_map.vh"

module tape_order_phase_sequencer
(
	input  wire        core_clk,
	input  wire        nrst,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire [8:0]  host_data_in,
	input  wire        request_strobe_ack,
	input  wire        end_service,
	input  wire        end_data_in,
	input  wire        host_acknowledge,
	input  wire        function_strobe,
	input  wire        address_valid,
	output reg  [7:0]  host_data_out,
	output reg         host_data_oe,
	output reg         service_request,
	output reg         service_call,
	output reg         end_data_enable,
	output reg         data_read_enable,
	output reg         load_error_byte,
	output reg         data_logic_reset,
	output reg         direction_bit_a,
	output reg         direction_bit_b,
	output reg         sense_phase,
	output reg         set_correction_phase
);

	localparam PATTERN_W = 9;

	// ----------------------------------------
	// State
	// ----------------------------------------
	reg        state_flag_a;
	reg        state_flag_b;
	reg        terminal_order_flag;
	reg        service_cycle_flag;
	reg        order_complete_flag;
	reg        unusual_end_flag;
	reg        correction_read_flag;
	reg        interrupt_request_flag;
	reg [6:0]  control;
	reg [7:0]  track_error_byte;
	reg [PATTERN_W-1:0] error_pattern_reg;
	reg        ack_prev;
	reg        strobe_prev;
	reg        rearm;

	wire [4:0] order_flags   = control[`CTL_ORDER_MSB:`CTL_ORDER_LSB];
	wire       write_busy    = control[`CTL_WRITE_BUSY];
	wire       shift_active  = control[`CTL_SHIFT];
	wire       halt_line     = host_data_in[`DL_HALT];
	wire       interrupt_line = host_data_in[`DL_INTERRUPT];

	// ----------------------------------------
	// Decodes
	// ----------------------------------------
	wire order_out   = state_flag_b & ~state_flag_a;
	wire select_time = state_flag_a & ~state_flag_b;
	wire sense_order = (order_flags == `ORDER_SENSE);
	wire corr_order  = order_flags[0] & ~order_flags[2] & ~order_flags[3] & ~order_flags[4];
	wire in_sense    = select_time & sense_order;
	wire in_corr     = select_time & corr_order & ~sense_order;
	wire erase_order = host_data_in[6] & host_data_in[7] & host_data_in[1]
		& host_data_in[2] & ~host_data_in[3];

	// Request falls on the rising edge of the strobe acknowledge
	wire rsd_fall = service_request & request_strobe_ack & ~ack_prev;
	wire fs_fall  = strobe_prev & ~function_strobe & host_acknowledge & address_valid;
	wire phase_strobe = fs_fall & (in_sense | in_corr) & service_call;

	// ----------------------------------------
	// APB access
	// ----------------------------------------
	wire setup     = psel & ~penable;
	wire wr_access = psel & penable & pready & pwrite;
	wire mapped    = (paddr == `REG_CONTROL) | (paddr == `REG_STATUS)
		| (paddr == `REG_TRACK_ERROR) | (paddr == `REG_ERROR_PATTERN)
		| (paddr == `REG_FLAG_CLEAR);
	wire wr_ctl    = wr_access & (paddr == `REG_CONTROL) & ~pslverr;
	wire wr_track  = wr_access & (paddr == `REG_TRACK_ERROR) & ~pslverr;
	wire wr_clear  = wr_access & (paddr == `REG_FLAG_CLEAR) & ~pslverr;
	wire idle      = ~state_flag_a & ~state_flag_b;
	wire start     = wr_ctl & pwdata[`CTL_START] & idle;

	wire [31:0] status_word = {23'h000000, service_request, interrupt_request_flag,
		correction_read_flag, unusual_end_flag, order_complete_flag,
		service_cycle_flag, terminal_order_flag, state_flag_b, state_flag_a};

	reg [31:0] next_prdata;

	always @*
	begin
		next_prdata = 32'h00000000;
		case (paddr)
			`REG_CONTROL:       next_prdata = {25'h0000000, control};
			`REG_STATUS:        next_prdata = status_word;
			`REG_TRACK_ERROR:   next_prdata = {24'h000000, track_error_byte};
			`REG_ERROR_PATTERN: next_prdata = {23'h000000, error_pattern_reg};
			default:            next_prdata = 32'h00000000;
		endcase
	end

	always @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= setup;
			pslverr <= setup & ~mapped;
			if (setup & ~pwrite)
				prdata <= next_prdata;
		end
	end

	always @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			control          <= `RST_CONTROL;
			track_error_byte <= `RST_TRACK_ERROR;
		end
		else
		begin
			if (wr_ctl)
				control <= pwdata[6:0];
			if (wr_track)
				track_error_byte <= pwdata[7:0];
		end
	end

	// ----------------------------------------
	// Edge sampling of host strobes
	// ----------------------------------------
	always @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ack_prev    <= 1'b0;
			strobe_prev <= 1'b0;
		end
		else
		begin
			ack_prev    <= request_strobe_ack;
			strobe_prev <= function_strobe;
		end
	end

	// ----------------------------------------
	// Flag update at start, flag clear write, phase strobe and request fall
	// ----------------------------------------
	reg next_a;
	reg next_b;
	reg next_term;
	reg next_cycle;
	reg next_complete;
	reg next_unusual;
	reg next_corr;
	reg next_int;
	reg next_rearm;

	always @*
	begin
		next_a        = state_flag_a;
		next_b        = state_flag_b;
		next_term     = terminal_order_flag;
		next_cycle    = service_cycle_flag;
		next_complete = order_complete_flag;
		next_unusual  = unusual_end_flag;
		next_corr     = correction_read_flag;
		next_int      = interrupt_request_flag;
		next_rearm    = 1'b0;
		if (wr_clear)
		begin
			next_complete = order_complete_flag & ~pwdata[`ST_COMPLETE];
			next_unusual  = unusual_end_flag & ~pwdata[`ST_UNUSUAL_END];
			next_corr     = correction_read_flag & ~pwdata[`ST_CORR_READ];
			next_int      = interrupt_request_flag & ~pwdata[`ST_INTERRUPT];
		end
		if (start)
		begin
			next_b     = 1'b1;
			next_cycle = 1'b1;
			next_term  = 1'b0;
		end
		if (phase_strobe)
			next_cycle = 1'b1;
		if (rsd_fall & order_out)
		begin
			if (terminal_order_flag)
			begin
				next_b     = 1'b0;
				next_term  = 1'b0;
				next_cycle = 1'b0;
				if (end_service & halt_line)
					next_unusual = 1'b1;
				else if (~erase_order)
					next_a = 1'b1;
				else
					next_complete = 1'b1;
			end
			else if (end_data_in & ~end_service & service_cycle_flag)
			begin
				next_term  = 1'b1;
				next_rearm = 1'b1;
			end
			else if (end_service)
			begin
				next_b     = 1'b0;
				next_cycle = 1'b0;
				if (erase_order)
					next_complete = 1'b1;
				else
					next_a = 1'b1;
			end
		end
		if (rsd_fall & (in_sense | in_corr))
		begin
			if (terminal_order_flag)
			begin
				next_complete = 1'b1;
				next_a        = 1'b0;
				next_term     = 1'b0;
				next_cycle    = 1'b0;
				if (interrupt_line)
					next_int = 1'b1;
				if (halt_line)
					next_unusual = 1'b1;
			end
			else
			begin
				if (in_corr)
					next_corr = 1'b1;
				if (end_service)
				begin
					next_complete = 1'b1;
					next_a        = 1'b0;
					next_cycle    = 1'b0;
				end
				else
				begin
					next_term  = 1'b1;
					next_rearm = 1'b1;
				end
			end
		end
	end

	always @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_flag_a           <= 1'b0;
			state_flag_b           <= 1'b0;
			terminal_order_flag    <= 1'b0;
			service_cycle_flag     <= 1'b0;
			order_complete_flag    <= 1'b0;
			unusual_end_flag       <= 1'b0;
			correction_read_flag   <= 1'b0;
			interrupt_request_flag <= 1'b0;
			rearm                  <= 1'b0;
		end
		else
		begin
			state_flag_a           <= next_a;
			state_flag_b           <= next_b;
			terminal_order_flag    <= next_term;
			service_cycle_flag     <= next_cycle;
			order_complete_flag    <= next_complete;
			unusual_end_flag       <= next_unusual;
			correction_read_flag   <= next_corr;
			interrupt_request_flag <= next_int;
			rearm                  <= next_rearm;
		end
	end

	// ----------------------------------------
	// Service request
	// ----------------------------------------
	// Request level after this edge, so the enables drop at the fall
	wire next_request = ~rsd_fall & (start | rearm | phase_strobe | service_request);
	always @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			service_request <= 1'b0;
		else if (rsd_fall)
			service_request <= 1'b0;
		else if (start | rearm | phase_strobe)
			service_request <= 1'b1;
	end

	// ----------------------------------------
	// Phase outputs
	// ----------------------------------------
	always @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sense_phase          <= 1'b0;
			set_correction_phase <= 1'b0;
			service_call         <= 1'b0;
			data_logic_reset     <= 1'b0;
			end_data_enable      <= 1'b0;
			data_read_enable     <= 1'b0;
			load_error_byte      <= 1'b0;
			direction_bit_a      <= 1'b1;
			direction_bit_b      <= 1'b1;
			host_data_out        <= 8'h00;
			host_data_oe         <= 1'b0;
		end
		else
		begin
			sense_phase          <= in_sense;
			set_correction_phase <= in_corr;
			service_call         <= (in_sense | in_corr) & ~next_cycle;
			data_logic_reset     <= in_corr & ~next_cycle;
			end_data_enable      <= (in_sense | in_corr) & next_cycle;
			data_read_enable     <= in_sense & ~next_term & next_request;
			load_error_byte      <= in_corr & ~next_term & next_request;
			if ((in_sense | in_corr) & next_cycle)
			begin
				direction_bit_a <= 1'b0;
				direction_bit_b <= in_corr;
			end
			else
			begin
				direction_bit_a <= 1'b1;
				direction_bit_b <= 1'b1;
			end
			host_data_out <= in_sense ? track_error_byte : 8'h00;
			host_data_oe  <= in_sense;
		end
	end

	// ----------------------------------------
	// Error pattern register
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < PATTERN_W; i = i + 1)
		begin : g_stage
			always @(posedge core_clk or negedge nrst)
			begin
				if (!nrst)
					error_pattern_reg[i] <= 1'b0;
				else if (data_logic_reset & ~correction_read_flag)
					error_pattern_reg[i] <= 1'b0;
				else if (load_error_byte & ~write_busy & ~shift_active & host_data_in[i])
					error_pattern_reg[i] <= 1'b1;
			end
		end
	endgenerate

endmodule // tape_order_phase_sequencer
`default_nettype wire

/* tape_order_phase_sequencer_props.sv */
`timescale 1ns/1ps
`default_nettype none
module tape_order_phase_sequencer_props
(
	input wire       core_clk,
	input wire       nrst,
	input wire       request_strobe_ack,
	input wire       host_acknowledge,
	input wire       function_strobe,
	input wire       address_valid,
	input wire       service_request,
	input wire       service_call,
	input wire       end_data_enable,
	input wire       data_read_enable,
	input wire       load_error_byte,
	input wire       data_logic_reset,
	input wire       direction_bit_a,
	input wire       direction_bit_b,
	input wire       host_data_oe,
	input wire       sense_phase,
	input wire       set_correction_phase
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	property p_one_phase;
		!(sense_phase && set_correction_phase);
	endproperty
	property p_sense_drive;
		sense_phase |-> host_data_oe;
	endproperty
	property p_sense_read;
		data_read_enable |-> sense_phase && !direction_bit_a && !direction_bit_b;
	endproperty
	property p_strobe;
		$fell(function_strobe) && host_acknowledge && address_valid && service_call
			&& (sense_phase || set_correction_phase) |-> ##[1:3] service_request;
	endproperty
	property p_fall;
		$rose(request_strobe_ack) && service_request |-> ##[1:3] !service_request;
	endproperty
	property p_load;
		load_error_byte |-> set_correction_phase && service_request;
	endproperty
	property p_corr_dir;
		set_correction_phase && end_data_enable |-> !direction_bit_a && direction_bit_b;
	endproperty
	property p_corr_reset;
		$rose(set_correction_phase) |-> ##[0:2] (data_logic_reset && service_call);
	endproperty
	a_one_phase: assert property (p_one_phase) else $error("both phases");
	a_sense_drive: assert property (p_sense_drive) else $error("no drive");
	a_sense_read: assert property (p_sense_read) else $error("read enable");
	a_strobe: assert property (p_strobe) else $error("no request");
	a_fall: assert property (p_fall) else $error("request held");
	a_load: assert property (p_load) else $error("load gate");
	a_corr_dir: assert property (p_corr_dir) else $error("direction");
	a_corr_reset: assert property (p_corr_reset) else $error("no reset");
	c_sense: cover property ($rose(sense_phase));
	c_corr: cover property ($rose(set_correction_phase));
	c_load: cover property (load_error_byte);
endmodule // tape_order_phase_sequencer_props
`default_nettype wire

/* host_channel_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_channel_model
(
	input  wire logic       core_clk,
	input  wire logic       service_request,
	input  wire logic       service_call,
	input  wire logic       es_in,
	input  wire logic       ed_in,
	input  wire logic [8:0] data_in,
	output logic      [8:0] host_data_in,
	output logic            request_strobe_ack,
	output logic            end_service,
	output logic            end_data_in,
	output logic            host_acknowledge,
	output logic            function_strobe,
	output logic            address_valid
);
	initial
	begin
		{request_strobe_ack, end_service, end_data_in} = 3'h0;
		{host_acknowledge, function_strobe, address_valid} = 3'h0;
		host_data_in = 9'h1FF;
	end
	// Answers a service call, then each request, after a pause
	always
	begin
		@(posedge core_clk);
		if (service_call)
		begin
			repeat (4) @(posedge core_clk);
			host_data_in <= data_in;
			{host_acknowledge, address_valid, function_strobe} <= 3'h7;
			@(posedge core_clk);
			function_strobe <= 1'b0;
			repeat (3) @(posedge core_clk);
			{host_acknowledge, address_valid} <= 2'h0;
		end
		else if (service_request)
		begin
			repeat (4) @(posedge core_clk);
			host_data_in <= data_in;
			end_service <= es_in;
			end_data_in <= ed_in;
			{request_strobe_ack, host_acknowledge} <= 2'h3;
			while (service_request)
				@(posedge core_clk);
			{request_strobe_ack, host_acknowledge, end_service, end_data_in} <= 4'h0;
			host_data_in <= ~data_in;
		end
	end
endmodule // host_channel_model
`default_nettype wire

/* tape_order_phase_sequencer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tape_order_map.vh"
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin fail_count++; \
	$display("ERROR %s exp %h got %h", n, e, a); end end
module tape_order_phase_sequencer_tb;
	logic        core_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00, host_data_out;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, er, es_in = 1'b0, ed_in = 1'b0;
	logic [8:0]  data_in = 9'h000, host_data_in;
	logic        request_strobe_ack, end_service, end_data_in, host_acknowledge;
	logic        function_strobe, address_valid, host_data_oe, service_request;
	logic        service_call, end_data_enable, data_read_enable, load_error_byte;
	logic        data_logic_reset, direction_bit_a, direction_bit_b;
	logic        sense_phase, set_correction_phase;
	int          fail_count = 0, samples_checked = 0;
	always #5 core_clk = ~core_clk;
	tape_order_phase_sequencer tape_order_phase_sequencer_inst (.core_clk(core_clk),
		.nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.host_data_in(host_data_in), .request_strobe_ack(request_strobe_ack),
		.end_service(end_service), .end_data_in(end_data_in),
		.host_acknowledge(host_acknowledge), .function_strobe(function_strobe),
		.address_valid(address_valid), .host_data_out(host_data_out),
		.host_data_oe(host_data_oe), .service_request(service_request),
		.service_call(service_call), .end_data_enable(end_data_enable),
		.data_read_enable(data_read_enable), .load_error_byte(load_error_byte),
		.data_logic_reset(data_logic_reset), .direction_bit_a(direction_bit_a),
		.direction_bit_b(direction_bit_b), .sense_phase(sense_phase),
		.set_correction_phase(set_correction_phase));
	host_channel_model host_channel_model_inst (.core_clk(core_clk),
		.service_request(service_request), .service_call(service_call), .es_in(es_in),
		.ed_in(ed_in), .data_in(data_in), .host_data_in(host_data_in),
		.request_strobe_ack(request_strobe_ack), .end_service(end_service),
		.end_data_in(end_data_in), .host_acknowledge(host_acknowledge),
		.function_strobe(function_strobe), .address_valid(address_valid));
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1)
			@(posedge core_clk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rchk(input logic [7:0] a, input logic [31:0] e, input string n);
		apb(1'b0, a, 32'h0);
		`CHK(n, e, rd)
	endtask
	// Sets the host answer, then waits out one request fall
	task fall(input logic es, input logic ed, input logic [8:0] d);
		es_in <= es;
		ed_in <= ed;
		data_in <= d;
		while (request_strobe_ack !== 1'b1)
			@(posedge core_clk);
		while (request_strobe_ack !== 1'b0)
			@(posedge core_clk);
	endtask
	task order(input logic [31:0] c);
		apb(1'b1, `REG_FLAG_CLEAR, 32'hF0);
		apb(1'b1, `REG_CONTROL, c);
		fall(1'b1, 1'b0, 9'h000);
	endtask
	task final_report;
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		#100000;
		fail_count++;
		final_report;
	end
	initial
	begin
		repeat (2) @(posedge core_clk);
		nrst <= 1'b1;
		#1 `CHK("dir", 2'h3, {direction_bit_a, direction_bit_b})
		rchk(`REG_STATUS, 32'h0, "status");
		rchk(`REG_ERROR_PATTERN, 32'h0, "pattern");
		apb(1'b0, 8'h14, 32'h0);
		`CHK("slverr", 1'b1, er)
		apb(1'b1, `REG_TRACK_ERROR, 32'hA5);
		$display("end reset");
		apb(1'b1, `REG_CONTROL, 32'h104);
		fall(1'b0, 1'b1, 9'h000);
		rchk(`REG_STATUS, 32'h10E, "oo_term");
		fall(1'b1, 1'b0, 9'h008);
		rchk(`REG_STATUS, 32'h020, "oo_halt");
		$display("end order out");
		order(32'h104);
		`CHK("sense", 2'h2, {sense_phase, set_correction_phase})
		`CHK("track", 9'h1A5, {host_data_oe, host_data_out})
		`CHK("sense_call", 2'h2, {service_call, data_logic_reset})
		fall(1'b1, 1'b0, 9'h000);
		rchk(`REG_STATUS, 32'h010, "sense_end");
		order(32'h104);
		fall(1'b0, 1'b0, 9'h000);
		rchk(`REG_STATUS, 32'h10D, "sense_term");
		fall(1'b1, 1'b0, 9'h001);
		rchk(`REG_STATUS, 32'h090, "sense_int");
		$display("end sense");
		order(32'h101);
		`CHK("corr", 2'h1, {sense_phase, set_correction_phase})
		`CHK("corr_call", 2'h3, {service_call, data_logic_reset})
		fall(1'b1, 1'b0, 9'h15A);
		rchk(`REG_STATUS, 32'h050, "corr_end");
		rchk(`REG_ERROR_PATTERN, 32'h15A, "pattern");
		order(32'h101);
		fall(1'b0, 1'b0, 9'h000);
		rchk(`REG_STATUS, 32'h14D, "corr_term");
		fall(1'b1, 1'b0, 9'h008);
		rchk(`REG_STATUS, 32'h070, "corr_halt");
		$display("end correction");
		final_report;
	end
endmodule // tape_order_phase_sequencer_tb
bind tape_order_phase_sequencer tape_order_phase_sequencer_props tape_order_phase_sequencer_props_inst
	(.core_clk(core_clk), .nrst(nrst), .request_strobe_ack(request_strobe_ack),
	.host_acknowledge(host_acknowledge), .function_strobe(function_strobe),
	.address_valid(address_valid), .service_request(service_request),
	.service_call(service_call), .end_data_enable(end_data_enable),
	.data_read_enable(data_read_enable), .load_error_byte(load_error_byte),
	.data_logic_reset(data_logic_reset), .direction_bit_a(direction_bit_a),
	.direction_bit_b(direction_bit_b), .host_data_oe(host_data_oe),
	.sense_phase(sense_phase), .set_correction_phase(set_correction_phase));
`default_nettype wire
